// ==== hdl/host_port_map.svh ====
// constants for the host port: port selects, reset values and timing
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

// port select codes on the two register-select inputs
`define HP_PORT_IQ        2'h0
`define HP_PORT_DQ        2'h1
`define HP_PORT_INT_ACK   2'h2
`define HP_PORT_INT_EN    2'h3

// reset values
`define HP_INT_EN_RST     8'h00
`define HP_PEND_RST       8'h00
`define HP_DATA_RST       16'h0000

// bit of the pending set that flags a write lost to a full buffer
`define HP_OVF_BIT        7

// request withdrawal bound after the serving strobe, and core clock period
`define HP_REQ_DROP_NS    50
`define HP_CLK_PERIOD_NS  25
`define HP_REQ_DROP_CYC   ((`HP_REQ_DROP_NS / `HP_CLK_PERIOD_NS) < 1 ? 1 : \
                           (`HP_REQ_DROP_NS / `HP_CLK_PERIOD_NS))

`endif

// ==== hdl/host_port_pkg.sv ====
// types shared by the host port files
package host_port_pkg;

  // access sequencer states
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_READ  = 2'b01,
    ACC_WRITE = 2'b10
  } acc_state_e;

endpackage

// ==== hdl/word_buffer2.sv ====
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps

module word_buffer2 #(
  parameter int WIDTH = 17
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] slot0_q;
  logic [WIDTH-1:0] slot1_q;
  logic [1:0]       count_q;
  logic             valid_q;
  wire  [1:0]       count_d;
  wire              push;
  wire              pop;

  // handshakes; slot0 is always the head
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (count_q != 2'd2);
  assign out_valid = valid_q; // registered so the draining side sees a flop
  assign out_data  = slot0_q;
  assign count_d   = count_q + {1'b0, push} - {1'b0, pop};

  // occupancy count and its registered non-empty flag
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_q <= 2'd0;
      valid_q <= 1'b0;
    end else begin
      count_q <= count_d;
      valid_q <= (count_d != 2'd0);
    end
  end

  // shift on pop, fill the first free slot on push
  always_ff @(posedge core_clk) begin
    if (pop) begin
      slot0_q <= (count_q == 2'd2) ? slot1_q : in_data;
    end else if (push && count_q == 2'd0) begin
      slot0_q <= in_data;
    end
    if (push && ((count_q == 2'd1 && !pop) || count_q == 2'd2)) begin
      slot1_q <= in_data;
    end
  end

endmodule

// ==== hdl/host_port.sv ====
// device-side processor bus port: queues, dma requests and interrupts
`timescale 1ns/1ps
`include "host_port_map.svh"

module host_port #(
  parameter int DW = 16,
  parameter int NI = 8
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst,
  // processor bus pins
  input  wire logic          sel_n,
  input  wire logic          rd_n,
  input  wire logic          wr_n,
  input  wire logic [1:0]    port_sel,
  input  wire logic [DW-1:0] data_in,
  output logic [DW-1:0]      data_out,
  output logic               data_oe,
  // open-drain dma requests, active high when released
  output logic               data_queue_dma_request,
  output logic               data_queue_dma_request_oe,
  output logic               instruction_queue_dma_request,
  output logic               instruction_queue_dma_request_oe,
  // interrupt pin
  output logic               int_req,
  // user side: words written by the processor, bit DW set for data queue
  output logic               wq_valid,
  input  wire logic          wq_ready,
  output logic [DW:0]        wq_data,
  // user side: words to be read out through the data queue
  input  wire logic          rq_valid,
  output logic               rq_ready,
  input  wire logic [DW-1:0] rq_data,
  // user side: queue direction and interrupt sources
  input  wire logic          dq_read_mode,
  input  wire logic [NI-2:0] int_src
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change taken when stages 2 and 3 agree
  logic [2:0]    sel_s_q;
  logic [2:0]    rd_s_q;
  logic [2:0]    wr_s_q;
  logic [1:0]    port_s1_q;
  logic [1:0]    port_s2_q;
  logic [1:0]    port_s3_q;
  logic [DW-1:0] din_s1_q;
  logic [DW-1:0] din_s2_q;
  logic [DW-1:0] din_s3_q;
  logic          sel_act_q;
  logic          rd_act_q;
  logic          wr_act_q;

  // shift chains; pins are active low so invert at entry
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_s_q <= 3'h0;
      rd_s_q  <= 3'h0;
      wr_s_q  <= 3'h0;
    end else begin
      sel_s_q <= {sel_s_q[1:0], ~sel_n};
      rd_s_q  <= {rd_s_q[1:0], ~rd_n};
      wr_s_q  <= {wr_s_q[1:0], ~wr_n};
    end
  end

  // address and data ride along; only stable inside a strobe
  always_ff @(posedge core_clk) begin
    port_s1_q <= port_sel;
    port_s2_q <= port_s1_q;
    port_s3_q <= port_s2_q;
    din_s1_q  <= data_in;
    din_s2_q  <= din_s1_q;
    din_s3_q  <= din_s2_q;
  end

  // filtered levels: hold until stages 2 and 3 agree on a new value
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_act_q <= 1'b0;
      rd_act_q  <= 1'b0;
      wr_act_q  <= 1'b0;
    end else begin
      if (sel_s_q[1] == sel_s_q[2]) sel_act_q <= sel_s_q[2];
      if (rd_s_q[1] == rd_s_q[2])   rd_act_q  <= rd_s_q[2];
      if (wr_s_q[1] == wr_s_q[2])   wr_act_q  <= wr_s_q[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // access sequencer
  host_port_pkg::acc_state_e state_q;
  host_port_pkg::acc_state_e state_d;
  logic [1:0]                port_q;

  wire rd_start  = sel_act_q && rd_act_q;
  wire wr_start  = sel_act_q && wr_act_q;
  wire rd_done   = (state_q == host_port_pkg::ACC_READ) && !rd_act_q;
  wire wr_done   = (state_q == host_port_pkg::ACC_WRITE) && !wr_act_q;
  wire in_access = (state_q != host_port_pkg::ACC_IDLE);

  // dma and programmed accesses take the same path
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      host_port_pkg::ACC_IDLE: begin
        if (rd_start) state_d = host_port_pkg::ACC_READ;
        else if (wr_start) state_d = host_port_pkg::ACC_WRITE;
      end
      host_port_pkg::ACC_READ: begin
        if (!rd_act_q) state_d = host_port_pkg::ACC_IDLE;
      end
      host_port_pkg::ACC_WRITE: begin
        if (!wr_act_q) state_d = host_port_pkg::ACC_IDLE;
      end
      default: state_d = host_port_pkg::ACC_IDLE;
    endcase
  end

  // state and port latched at strobe start
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= host_port_pkg::ACC_IDLE;
      port_q  <= `HP_PORT_IQ;
    end else begin
      state_q <= state_d;
      if (!in_access) port_q <= port_s3_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write path through the two-entry buffer
  logic          buf_in_ready;
  wire           wr_is_queue = (port_q == `HP_PORT_IQ) || (port_q == `HP_PORT_DQ);
  wire           buf_push    = wr_done && wr_is_queue;
  wire           wr_lost     = buf_push && !buf_in_ready;
  logic [DW-1:0] wr_word_q;

  // word captured while the write strobe is still low; data is settled then
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_word_q <= `HP_DATA_RST;
    end else if (state_q == host_port_pkg::ACC_WRITE && wr_act_q) begin
      wr_word_q <= din_s3_q;
    end
  end

  // deposit writes land here
  word_buffer2 #(.WIDTH(DW + 1)) u_wbuf (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (buf_push),
    .in_ready  (buf_in_ready),
    .in_data   ({port_q == `HP_PORT_DQ, wr_word_q}),
    .out_valid (wq_valid),
    .out_ready (wq_ready),
    .out_data  (wq_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // interrupt pending and enable
  logic [NI-1:0] pend_q;
  logic [NI-1:0] int_en_q;
  wire  [NI-1:0] hw_set  = {wr_lost, int_src};
  wire           ack_wr  = wr_done && (port_q == `HP_PORT_INT_ACK);
  wire           en_wr   = wr_done && (port_q == `HP_PORT_INT_EN);
  wire  [NI-1:0] ack_clr = ack_wr ? wr_word_q[NI-1:0] : '0;

  // ones clear, zeros keep; a new event in the same cycle wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_q   <= `HP_PEND_RST;
      int_en_q <= `HP_INT_EN_RST;
    end else begin
      pend_q <= (pend_q & ~ack_clr) | hw_set;
      if (en_wr) int_en_q <= wr_word_q[NI-1:0];
    end
  end

  // level output while any enabled request stays pending
  always_ff @(posedge core_clk) begin
    if (rst) int_req <= 1'b0;
    else int_req <= |(pend_q & int_en_q);
  end

  ////////////////////////////////////////////////////////////////////////
  // read path; fetch reads pop the read-out word
  logic [DW-1:0] rd_mux;

  assign rd_mux = (port_q == `HP_PORT_DQ)      ? rq_data :
                  (port_q == `HP_PORT_INT_ACK) ? {{(DW-NI){1'b0}}, pend_q} :
                  (port_q == `HP_PORT_INT_EN)  ? {{(DW-NI){1'b0}}, int_en_q} :
                  `HP_DATA_RST;

  // drive the bus only while the read strobe is seen
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_out <= `HP_DATA_RST;
      data_oe  <= 1'b0;
      rq_ready <= 1'b0;
    end else begin
      data_out <= rd_mux;
      data_oe  <= (state_q == host_port_pkg::ACC_READ) && rd_act_q;
      rq_ready <= rd_done && (port_q == `HP_PORT_DQ) && rq_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dma requests: released high only when idle and able to serve a word.
  // dropping at strobe detection keeps the deposit/next cycle safe even
  // with the single wait state; the synchroniser sets the latency floor.
  wire dq_ok = dq_read_mode ? (rq_valid && !rq_ready) : buf_in_ready;
  wire iq_ok = buf_in_ready && !dq_read_mode;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_queue_dma_request        <= 1'b0;
      instruction_queue_dma_request <= 1'b0;
    end else begin
      // withdrawn on the strobe edge seen, restored after it ends
      data_queue_dma_request <= dq_ok && !in_access && !rd_start
                                && !wr_start;
      instruction_queue_dma_request <= iq_ok && !in_access && !rd_start
                                       && !wr_start;
    end
  end

  // open drain: pull low when not requesting
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_queue_dma_request_oe        <= 1'b1;
      instruction_queue_dma_request_oe <= 1'b1;
    end else begin
      data_queue_dma_request_oe <= !(dq_ok && !in_access && !rd_start && !wr_start);
      instruction_queue_dma_request_oe <= !(iq_ok && !in_access && !rd_start
                                            && !wr_start);
    end
  end

endmodule

// ==== verification/host_port_assertions.sv ====
// pin-level checks for the host port
`timescale 1ns/1ps
`include "host_port_map.svh"

module host_port_assertions #(parameter int DW = 16, parameter int NI = 8) (
  // clock, reset and bus pins
  input wire logic core_clk, rst, sel_n, rd_n, wr_n, data_oe, int_req,
  input wire logic [1:0] port_sel,
  input wire logic [DW-1:0] data_in, data_out, rq_data,
  // request pins and user side
  input wire logic data_queue_dma_request, data_queue_dma_request_oe,
  input wire logic instruction_queue_dma_request, instruction_queue_dma_request_oe,
  input wire logic wq_valid, wq_ready, rq_valid, rq_ready, dq_read_mode,
  input wire logic [DW:0] wq_data,
  input wire logic [NI-2:0] int_src
);
  logic [3:0] wr_age_q, src_age_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////
  // cycles since a write strobe or event; saturates so stale causes never count
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_age_q  <= 4'hf;
      src_age_q <= 4'hf;
    end else begin
      wr_age_q  <= !wr_n ? 4'h0 : wr_age_q + 4'(wr_age_q != 4'hf);
      src_age_q <= |int_src ? 4'h0 : src_age_q + 4'(src_age_q != 4'hf);
    end
  end

  ////////////////////////////////////////////////////////////
  // requests withdrawn while the serving strobe is low
  iq_drop_a: assert property ($fell(wr_n) && !sel_n && port_sel == `HP_PORT_IQ
    |-> ##[1:6] instruction_queue_dma_request_oe) else $error("iq request held");
  dq_wr_drop_a: assert property ($fell(wr_n) && !sel_n && port_sel == `HP_PORT_DQ
    |-> ##[1:6] data_queue_dma_request_oe) else $error("dq request held on write");
  dq_rd_drop_a: assert property ($fell(rd_n) && !sel_n && port_sel == `HP_PORT_DQ
    |-> ##[1:6] data_queue_dma_request_oe) else $error("dq request held on read");
  // instruction request stays off in read-out mode; pin pairs stay complementary
  iq_mode_a: assert property (dq_read_mode |=> !instruction_queue_dma_request)
    else $error("iq request in read mode");
  dq_pair_a: assert property (data_queue_dma_request != data_queue_dma_request_oe)
    else $error("dq request pins disagree");
  iq_pair_a: assert property (
    instruction_queue_dma_request != instruction_queue_dma_request_oe)
    else $error("iq request pins disagree");
  // data driven only around a read strobe
  read_drive_a: assert property ($fell(rd_n) && !sel_n |-> ##[2:6] data_oe)
    else $error("read data not driven");
  read_release_a: assert property ($rose(rd_n) |-> ##[1:6] !data_oe)
    else $error("read drive not released");
  write_quiet_a: assert property ($fell(wr_n) |-> !data_oe [*6])
    else $error("data driven in a write");
  // interrupt moves only after a write or an event
  int_clear_a: assert property ($fell(int_req) |-> wr_age_q < 4'ha)
    else $error("interrupt dropped without write");
  int_raise_a: assert property (
    $rose(int_req) |-> wr_age_q < 4'ha || src_age_q < 4'h4)
    else $error("interrupt raised without cause");
  // stalled word waits unchanged; consume is one pulse
  wq_hold_a: assert property (wq_valid && !wq_ready |=> wq_valid && $stable(wq_data))
    else $error("queued word changed under stall");
  rq_pulse_a: assert property (rq_ready |=> !rq_ready)
    else $error("consume not a pulse");
endmodule

// ==== verification/proc_bus_model.sv ====
// processor side of the host bus: select, strobes and write data
`timescale 1ns/1ps

module proc_bus_model (
  // clock
  input wire logic core_clk,
  // pins toward the port
  output logic sel_n, rd_n, wr_n,
  output logic [1:0] port_sel,
  output logic [15:0] data_in,
  // read data
  input wire logic [15:0] data_out
);
  initial begin
    sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    port_sel = 2'h0;
    data_in = 16'h5a5a;
  end

  ////////////////////////////////////////////////////////////
  // one cycle, dma or programmed alike, moved on the falling edge
  task automatic access(input logic wr, input logic [1:0] p, input logic [15:0] d,
                        output logic [15:0] q);
    @(negedge core_clk);
    sel_n = 1'b0;
    port_sel = p;                     // two low bits only, upper ones zero
    data_in = wr ? d : ~data_in;
    @(negedge core_clk);              // strobe after latched select
    rd_n = wr;
    wr_n = !wr;
    repeat (10) @(negedge core_clk);  // spans one wait state
    q = data_out;                     // taken mid-cycle, where the word has settled
    rd_n = 1'b1;                      // final bus state ends a read
    wr_n = 1'b1;                      // write drive ends with the strobe
    @(negedge core_clk);
    sel_n = 1'b1;
    data_in = ~data_in;               // released bus never shows the last word
    repeat (8) @(negedge core_clk);   // idle until the next latch strobe
  endtask
endmodule

// ==== verification/host_port_tb_top.sv ====
// self-checking bench for the host port
`timescale 1ns/1ps
`include "host_port_map.svh"

module host_port_tb_top;
  logic        core_clk, rst, sel_n, rd_n, wr_n, data_oe, int_req, stall, dq_oe, iq_oe;
  logic        wq_valid, wq_ready, rq_valid, rq_ready, dq_read_mode;
  logic [1:0]  port_sel;
  logic [15:0] data_in, data_out, rq_data, q;
  logic [15:0] lfsr_q = 16'h9da8;
  logic [16:0] wq_data;
  logic [6:0]  int_src;
  logic [16:0] exp_wq[$];
  int          error_cnt, num_checks, cyc, pend, en, rq_cnt;

  host_port uut (.core_clk(core_clk), .rst(rst), .sel_n(sel_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_sel(port_sel), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .data_queue_dma_request(), .data_queue_dma_request_oe(dq_oe),
    .instruction_queue_dma_request(), .instruction_queue_dma_request_oe(iq_oe),
    .int_req(int_req), .wq_valid(wq_valid), .wq_ready(wq_ready), .wq_data(wq_data),
    .rq_valid(rq_valid), .rq_ready(rq_ready), .rq_data(rq_data),
    .dq_read_mode(dq_read_mode), .int_src(int_src));
  proc_bus_model bus (.core_clk(core_clk), .sel_n(sel_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_sel(port_sel), .data_in(data_in), .data_out(data_out));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // write plus the reference model's view of it; full buffer refuses
  task automatic wr(input logic [1:0] p, input logic [15:0] d);
    if (p == `HP_PORT_INT_ACK) pend = pend & ~int'(d);
    else if (p == `HP_PORT_INT_EN) en = d[7:0];
    else if (stall && exp_wq.size() > 1) pend = pend | 8'h80;
    else exp_wq.push_back({p[0], d});
    bus.access(1'b1, p, d, q);
  endtask

  task automatic rd(input logic [1:0] p, input logic [15:0] e);
    bus.access(1'b0, p, 16'h0000, q);
    chk(17'(q), 17'(e));
  endtask

  task automatic ichk();
    repeat (4) @(negedge core_clk);
    chk(17'(int_req), 17'((pend & en) != 0));
  endtask

  task automatic pulse(input int k);
    @(negedge core_clk);
    int_src = 7'(1 << k);
    @(negedge core_clk);
    int_src = 7'h00;
    pend = pend | (1 << k);
  endtask

  ////////////////////////////////////////////////////////////
  // lfsr and user-side drain with random stalls, launched on the falling edge
  always @(negedge core_clk) begin
    lfsr_q <= lfsr(lfsr_q);
    wq_ready <= !stall && lfsr_q[3];
  end

  // every popped word must be the next one written; reads consumed are counted
  always @(posedge core_clk) begin
    cyc++;
    if (rq_ready) rq_cnt++;
    if (!rst && wq_valid && wq_ready) chk(wq_data, exp_wq.pop_front());
    if (cyc == 6000) begin
      error_cnt++;
      $display("ERROR %0t run hung", $time);
      end_sim();
    end
  end

  initial begin
    rst = 1'b1;
    stall = 1'b1;
    rq_valid = 1'b0;
    rq_data = 16'h0000;
    dq_read_mode = 1'b0;
    int_src = 7'h00;
    repeat (12) @(negedge core_clk);
    chk(17'({int_req, data_oe, dq_oe, iq_oe}), 17'h3);
    rst = 1'b0;
    repeat (6) @(negedge core_clk);
    chk(17'({dq_oe, iq_oe}), 17'h0);
    for (int i = 0; i < 3; i++) wr(2'(i % 2), lfsr_q);
    chk(17'({dq_oe, iq_oe}), 17'h3);
    rd(`HP_PORT_INT_ACK, 16'h0080);
    stall = 1'b0;
    for (int i = 0; i < 8; i++) wr(2'(i % 2), lfsr_q);
    repeat (20) @(negedge core_clk);
    chk(17'(exp_wq.size()), 17'h0);
    $display("queue test done");
    wr(`HP_PORT_INT_EN, 16'h00ff);
    rd(`HP_PORT_INT_EN, 16'h00ff);
    ichk();
    wr(`HP_PORT_INT_ACK, 16'h007f);
    ichk();
    wr(`HP_PORT_INT_ACK, 16'h0080);
    ichk();
    for (int k = 0; k < 7; k++) begin
      pulse(k);
      ichk();
      wr(`HP_PORT_INT_ACK, 16'(1 << k));
      ichk();
    end
    wr(`HP_PORT_INT_EN, 16'h0000);
    pulse(3);
    ichk();
    rd(`HP_PORT_INT_ACK, 16'h0008);
    wr(`HP_PORT_INT_ACK, 16'h0008);
    $display("interrupt test done");
    dq_read_mode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rq_data = lfsr_q;
      rq_valid = 1'b1;
      repeat (4) @(negedge core_clk);
      chk(17'({dq_oe, iq_oe}), 17'h1);
      rd(`HP_PORT_DQ, rq_data);
    end
    chk(17'(rq_cnt), 17'h4);
    rd(`HP_PORT_IQ, 16'h0000);
    $display("read-out test done");
    end_sim();
  end
endmodule

bind host_port host_port_assertions #(.DW(DW), .NI(NI)) chk_i (.*);
